// [dcdc_converter_control_regs.sv]
// What this block does
// - Passive diode mode disables bypass switch control
// - Pulse field selects none, 20, 40, 80 ns
// - Switch select: 0 large, 1 small switches
// - Sync bit aligns ADC tracking and SAR clock
// - Three-bit code sets target output voltage
// - Reset loads usable default 0x21
`timescale 1ns/1ps
module dcdc_converter_control_regs
    import dcdc_ctrl_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [3:0] SFR_PAGE,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       BYPASS_ACTIVE,
    input  wire logic       QUIET_INTERVAL,
    input  wire logic       SWITCH_REQ,
    output logic            SWITCH_GATE,
    output logic      [1:0] MIN_PULSE_WIDTH,
    output logic            SWITCH_SIZE_SELECT,
    output logic            ADC_SYNC_EN,
    output logic            ADC_TRACK_EN,
    output logic      [2:0] OUTPUT_VOLTAGE_SELECT,
    output logic            BYPASS_CTRL_EN
);

    logic [7:0] converter_control_reg_r;
    logic       passive_diode_enable_r;
    wire  [1:0] pin_clean;
    logic [3:0] min_cycles;
    logic [7:0] mode_read;
    logic [7:0] read_mux;

    wire sel_ctrl = (SFR_ADDR == CTRL_ADDR) && (SFR_PAGE == CTRL_PAGE);
    wire sel_mode = (SFR_ADDR == MODE_ADDR) && (SFR_PAGE == MODE_PAGE);
    wire wr_ctrl  = SFR_WR && sel_ctrl;
    wire wr_mode  = SFR_WR && sel_mode;

    wire [1:0] pin_raw     = {QUIET_INTERVAL, BYPASS_ACTIVE};
    wire       bypass_flag = pin_clean[0];
    wire       quiet_now   = pin_clean[1];

    wire [1:0] min_pulse_width = converter_control_reg_r[PULSE_HI:PULSE_LO];
    wire       sync_en         = converter_control_reg_r[SYNC_BIT];
    wire       size_nxt        = converter_control_reg_r[SWSIZE_BIT];
    wire [2:0] vout_nxt        = converter_control_reg_r[VOUT_HI:VOUT_LO];
    wire       track_nxt       = sync_en ? quiet_now : 1'b1;
    wire       bypass_ctrl_nxt = ~passive_diode_enable_r;

    // Pulse-width code to whole cycles of the system clock
    function automatic logic [3:0] pulse_cycles(input logic [1:0] code);
        case (code)
            2'h1:    return PULSE_01_CYC;
            2'h2:    return PULSE_10_CYC;
            2'h3:    return PULSE_11_CYC;
            default: return 4'h0;
        endcase
    endfunction

    assign min_cycles = pulse_cycles(min_pulse_width);

    // Mode reads: bypass flag at bit 3, unused bits zero
    assign mode_read = {4'h0, bypass_flag, 2'h0,
                        passive_diode_enable_r};
    assign read_mux  = sel_ctrl ? converter_control_reg_r :
                       sel_mode ? mode_read : 8'h00;

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            converter_control_reg_r <= CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            converter_control_reg_r <= SFR_WDATA;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            passive_diode_enable_r <= MODE_RESET[PASSIVE_BIT];
        end
        else if (wr_mode)
        begin
            passive_diode_enable_r <= SFR_WDATA[PASSIVE_BIT];
        end
    end

    // Analog pins: three stages, a change counts once the last two agree
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_pin_sync
            logic [2:0] sync_r;
            logic       clean_r;

            always_ff @(posedge SYS_CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    sync_r  <= 3'h0;
                    clean_r <= 1'b0;
                end
                else
                begin
                    sync_r <= {sync_r[1:0], pin_raw[g]};
                    if (sync_r[2] == sync_r[1])
                    begin
                        clean_r <= sync_r[2];
                    end
                end
            end

            assign pin_clean[g] = clean_r;
        end
    endgenerate

    // Read data registered; reads change no state
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SFR_RDATA <= 8'h00;
        end
        else if (SFR_RD)
        begin
            SFR_RDATA <= read_mux;
        end
    end

    // Each output follows its field one clock later, so the analog side
    // never sees a half-written register
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            MIN_PULSE_WIDTH <= CTRL_RESET[PULSE_HI:PULSE_LO];
        end
        else
        begin
            MIN_PULSE_WIDTH <= min_pulse_width;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            SWITCH_SIZE_SELECT <= CTRL_RESET[SWSIZE_BIT];
        end
        else
        begin
            SWITCH_SIZE_SELECT <= size_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ADC_SYNC_EN <= CTRL_RESET[SYNC_BIT];
        end
        else
        begin
            ADC_SYNC_EN <= sync_en;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ADC_TRACK_EN <= ~CTRL_RESET[SYNC_BIT];
        end
        else
        begin
            ADC_TRACK_EN <= track_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            OUTPUT_VOLTAGE_SELECT <= CTRL_RESET[VOUT_HI:VOUT_LO];
        end
        else
        begin
            OUTPUT_VOLTAGE_SELECT <= vout_nxt;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BYPASS_CTRL_EN <= ~MODE_RESET[PASSIVE_BIT];
        end
        else
        begin
            BYPASS_CTRL_EN <= bypass_ctrl_nxt;
        end
    end

    min_pulse_stretch u_stretch
    (
        .clk        (SYS_CLK),
        .rst_n      (RST_N),
        .min_cycles (min_cycles),
        .req        (SWITCH_REQ),
        .gate       (SWITCH_GATE)
    );

endmodule

// [dcdc_ctrl_monitor.sv]
`timescale 1ns/1ps
module dcdc_ctrl_mon
    import dcdc_ctrl_pkg::*;
(
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [3:0] SFR_PAGE,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       SWITCH_REQ,
    input wire logic       SWITCH_GATE,
    input wire logic [1:0] MIN_PULSE_WIDTH,
    input wire logic       SWITCH_SIZE_SELECT,
    input wire logic       ADC_SYNC_EN,
    input wire logic       ADC_TRACK_EN,
    input wire logic [2:0] OUTPUT_VOLTAGE_SELECT,
    input wire logic       BYPASS_CTRL_EN
);
    wire wc = SFR_WR && SFR_ADDR == CTRL_ADDR && SFR_PAGE == CTRL_PAGE;
    wire wm = SFR_WR && SFR_ADDR == MODE_ADDR && SFR_PAGE == MODE_PAGE;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_pulse_field: assert property (wc |-> ##2
        MIN_PULSE_WIDTH == $past(SFR_WDATA[7:6], 2)) else $error("pulse");
    a_switch_size: assert property (wc |-> ##2
        SWITCH_SIZE_SELECT == $past(SFR_WDATA[5], 2)) else $error("size");
    a_sync_follow: assert property (wc |-> ##2
        ADC_SYNC_EN == $past(SFR_WDATA[3], 2)) else $error("sync");
    a_vout_code: assert property (wc |-> ##2
        OUTPUT_VOLTAGE_SELECT == $past(SFR_WDATA[2:0], 2)) else $error("vout");
    a_passive_mode: assert property (wm |-> ##2
        BYPASS_CTRL_EN == !$past(SFR_WDATA[0], 2)) else $error("passive");
    a_track_free: assert property (!ADC_SYNC_EN [*2] |-> ADC_TRACK_EN)
        else $error("track");
    a_read_hold: assert property (!SFR_RD |=> $stable(SFR_RDATA))
        else $error("rdata");
    a_gate_req: assert property (SWITCH_REQ |=> SWITCH_GATE)
        else $error("gate");
endmodule
bind dcdc_converter_control_regs dcdc_ctrl_mon mon_u
(
    .SYS_CLK               (SYS_CLK),
    .RST_N                 (RST_N),
    .SFR_ADDR              (SFR_ADDR),
    .SFR_PAGE              (SFR_PAGE),
    .SFR_WDATA             (SFR_WDATA),
    .SFR_WR                (SFR_WR),
    .SFR_RD                (SFR_RD),
    .SFR_RDATA             (SFR_RDATA),
    .SWITCH_REQ            (SWITCH_REQ),
    .SWITCH_GATE           (SWITCH_GATE),
    .MIN_PULSE_WIDTH       (MIN_PULSE_WIDTH),
    .SWITCH_SIZE_SELECT    (SWITCH_SIZE_SELECT),
    .ADC_SYNC_EN           (ADC_SYNC_EN),
    .ADC_TRACK_EN          (ADC_TRACK_EN),
    .OUTPUT_VOLTAGE_SELECT (OUTPUT_VOLTAGE_SELECT),
    .BYPASS_CTRL_EN        (BYPASS_CTRL_EN)
);

// [dcdc_ctrl_pkg.sv]
package dcdc_ctrl_pkg;

    localparam int unsigned CLK_MHZ = 25;

    // SFR map
    localparam logic [7:0] CTRL_ADDR = 8'h97;
    localparam logic [3:0] CTRL_PAGE = 4'h0;
    localparam logic [7:0] MODE_ADDR = 8'h94;
    localparam logic [3:0] MODE_PAGE = 4'hF;

    // Control register fields
    localparam int PULSE_HI = 7;
    localparam int PULSE_LO = 6;
    localparam int SWSIZE_BIT = 5;
    localparam int RSVD_BIT = 4;
    localparam int SYNC_BIT = 3;
    localparam int VOUT_HI = 2;
    localparam int VOUT_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h21;

    // Mode register fields
    localparam int PASSIVE_BIT = 0;
    localparam int BYPFLAG_BIT = 3;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Minimum pulse widths
    localparam int unsigned PULSE_01_NS = 20;
    localparam int unsigned PULSE_10_NS = 40;
    localparam int unsigned PULSE_11_NS = 80;

    function automatic logic [3:0] ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1)
        begin
            c = 1;
        end
        return c[3:0];
    endfunction

    localparam logic [3:0] PULSE_01_CYC = ns_to_cycles(PULSE_01_NS);
    localparam logic [3:0] PULSE_10_CYC = ns_to_cycles(PULSE_10_NS);
    localparam logic [3:0] PULSE_11_CYC = ns_to_cycles(PULSE_11_NS);

endpackage

// [min_pulse_stretch.sv]
`timescale 1ns/1ps
module min_pulse_stretch
    import dcdc_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] min_cycles,
    input  wire logic       req,
    output logic            gate
);

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic       req_d_r;
    wire        rise = req & ~req_d_r;

    // Hold the gate open for at least min_cycles after a request starts
    assign cnt_nxt = rise ? min_cycles :
                     (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r   <= 4'h0;
            req_d_r <= 1'b0;
            gate    <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            req_d_r <= req;
            gate    <= req | (cnt_nxt != 4'h0);
        end
    end

endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench
    import dcdc_ctrl_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n, wr, rd, byp, qt, rq, gate, sws, sen, trk, bce;
    logic [7:0] ad, wd, rdat, rv;
    logic [3:0] pg;
    logic [1:0] mpw;
    logic [2:0] output_voltage_select;
    int         err_total, checks_done, cyc;
    dcdc_converter_control_regs dut_u (.SYS_CLK(clk), .RST_N(rst_n),
        .SFR_ADDR(ad), .SFR_PAGE(pg), .SFR_WDATA(wd), .SFR_WR(wr),
        .SFR_RD(rd), .SFR_RDATA(rdat), .BYPASS_ACTIVE(byp),
        .QUIET_INTERVAL(qt), .SWITCH_REQ(rq), .SWITCH_GATE(gate),
        .MIN_PULSE_WIDTH(mpw), .SWITCH_SIZE_SELECT(sws), .ADC_SYNC_EN(sen),
        .ADC_TRACK_EN(trk), .OUTPUT_VOLTAGE_SELECT(output_voltage_select),
        .BYPASS_CTRL_EN(bce));
    always #20 clk = ~clk;
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task conclude;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            conclude;
        end
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bus cycle: write when w, else read into rv
    task rw(input logic w, input logic [7:0] a, input logic [3:0] p,
            input logic [7:0] d);
        tick(1);
        {ad, pg, wd, wr, rd} = {a, p, d, w, !w};
        tick(1);
        {wr, rd} = 2'b00;
        rv = rdat;
    endtask
    task t_reset;
        chk({mpw, sws, 1'b0, sen, output_voltage_select}, 8'h21);
        chk({6'h00, trk, bce}, 8'h03);
        rw(0, CTRL_ADDR, CTRL_PAGE, 8'h00);
        chk(rv, 8'h21);
        $display("reset done");
    endtask
    task t_fields;
        logic [7:0] v;
        // Reserved bit always written zero
        for (int i = 0; i < 8; i++)
        begin
            v = {i[1:0], i[0], 1'b0, i[1], i[2:0]};
            rw(1, CTRL_ADDR, CTRL_PAGE, v);
            rw(0, CTRL_ADDR, CTRL_PAGE, 8'h00);
            chk(rv, v);
            chk({mpw, sws, 1'b0, sen, output_voltage_select}, v);
        end
        $display("fields done");
    endtask
    task t_mode;
        rw(1, MODE_ADDR, MODE_PAGE, 8'hFF);
        rw(0, MODE_ADDR, MODE_PAGE, 8'h00);
        chk(rv, 8'h09);
        chk(bce, 1'b0);
        rw(1, 8'h96, CTRL_PAGE, 8'hFF);
        rw(0, 8'h96, CTRL_PAGE, 8'hFF);
        chk(rv, 8'h00);
        rw(0, CTRL_ADDR, MODE_PAGE, 8'h00);
        chk(rv, 8'h00);
        rw(1, MODE_ADDR, MODE_PAGE, 8'h00);
        rw(0, CTRL_ADDR, CTRL_PAGE, 8'h00);
        chk(rv, 8'hEF);
        chk(bce, 1'b1);
        // Bypass indicator low must read back as a clear bit 3
        byp = 0;
        tick(6);
        rw(0, MODE_ADDR, MODE_PAGE, 8'h00);
        chk(rv, 8'h00);
        $display("mode done");
    endtask
    task t_pulse;
        for (int c = 0; c < 4; c++)
        begin
            rw(1, CTRL_ADDR, CTRL_PAGE, {c[1:0], 6'h01});
            tick(2);
            rq = 1;
            tick(1);
            chk(gate, 1'b1);
            rq = 0;
            tick(1);
            // Only 80 ns outlasts one 40 ns clock period
            chk(gate, c == 3);
            tick(4);
            chk(gate, 1'b0);
        end
        $display("pulse done");
    endtask
    task t_sync;
        rw(1, CTRL_ADDR, CTRL_PAGE, 8'h09);
        tick(6);
        chk(trk, 1'b0);
        qt = 1;
        tick(6);
        chk(trk, 1'b1);
        qt = 0;
        rw(1, CTRL_ADDR, CTRL_PAGE, 8'h01);
        tick(6);
        chk({sen, trk}, 2'b01);
        $display("sync done");
    endtask
    initial
    begin
        {rst_n, ad, pg, wd, wr, rd, rq, qt} = '0;
        byp = 1;
        tick(16);
        rst_n = 1;
        t_reset;
        t_fields;
        t_mode;
        t_pulse;
        t_sync;
        conclude;
    end
endmodule
